// ===== verilog/seu_pkg.sv
// Constants shared by the servo encoder and setpoint unit.
// Assumes a single 20 MHz system clock and a plain byte-addressed register port.
package seu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing.
    localparam int REF_CLK_HZ   = 20_000_000;
    localparam int EDGE_NS      = 250;
    localparam int EDGE_CYC     = (EDGE_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int TRACK_MAX_HZ = 500_000;
    localparam int TRACK_CYC    = REF_CLK_HZ / TRACK_MAX_HZ;
    localparam int HOLD_MS      = 1000;
    localparam int HOLD_CYC_DEF = HOLD_MS * (REF_CLK_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////////
    // Widths, axis counts and setpoint scaling.
    localparam int AW          = 8;
    localparam int DW          = 32;
    localparam int POS_W       = 32;
    localparam int SP_W        = 16;
    localparam int NUM_IN_DEF  = 6;
    localparam int NUM_OUT_DEF = 7;
    localparam int SP_LSB_UV   = 406;
    localparam int SP_RAPID_MV = 10_000;
    localparam int SP_RAPID    = SP_RAPID_MV * 1000 / SP_LSB_UV;
    localparam int SP_MAX      = 2 ** (SP_W - 1) - 1;
    localparam int SP_MIN      = -(2 ** (SP_W - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses.
    localparam logic [AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [AW-1:0] REG_STATUS = 8'h04;
    localparam logic [AW-1:0] REG_MASK   = 8'h08;
    localparam logic [AW-1:0] REG_LEVEL  = 8'h0C;
    localparam logic [AW-1:0] REG_RAPID  = 8'h10;
    localparam int            REG_LSB    = 2;
    localparam int            PAGE_LSB   = 5;
    localparam logic [2:0]    POS_PAGE   = 3'h1;
    localparam logic [2:0]    SP_PAGE    = 3'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Status and level fields.
    localparam int ST_ERR_LSB  = 0;
    localparam int ST_REF_LSB  = 8;
    localparam int ST_DROP_BIT = 16;
    localparam int ST_HOLD_BIT = 17;
    localparam int LV_READY    = 0;
    localparam int LV_HOLD     = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Encoder pin vector of one axis and its idle level.
    localparam int             NPINS   = 7;
    localparam int             PIN_AP  = 0;
    localparam int             PIN_AN  = 1;
    localparam int             PIN_BP  = 2;
    localparam int             PIN_BN  = 3;
    localparam int             PIN_RP  = 4;
    localparam int             PIN_RN  = 5;
    localparam int             PIN_FN  = 6;
    localparam logic [NPINS-1:0] PIN_IDLE = 7'h6A;

endpackage : seu_pkg

// ===== verilog/seu_axis.sv
// One measuring input: pin synchronisers, differential check, quadrature decode.
// Assumes pins asynchronous to ref_clk and a position counter read by the top.
module seu_axis
    import seu_pkg::*;
(
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // Encoder pins and configuration.
    input  wire logic [NPINS-1:0] pins,
    input  wire logic             invert,
    // Results.
    output logic [POS_W-1:0]      position,
    output logic                  errPulse,
    output logic                  refPulse
);

    typedef struct packed {
        logic [2:0][NPINS-1:0] sync;
        logic [NPINS-1:0]      lvl;
        logic                  badPrev;
        logic [POS_W-1:0]      pos;
        logic                  errPulse;
        logic                  refPulse;
    } seu_axis_type;

    localparam seu_axis_type RST = '{sync: {3{PIN_IDLE}}, lvl: PIN_IDLE, default: '0};

    seu_axis_type st;
    seu_axis_type next_st;
    logic [NPINS-1:0] agree;
    logic [NPINS-1:0] newLvl;
    logic             aCh;
    logic             bCh;
    logic             fwd;
    logic             bad;
    logic             step;
    logic             lvlEqA;
    logic             lvlBad;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////
    // A bit is taken only once the second and third stages agree, which
    // costs three cycles and stays well inside the least edge spacing.
    assign agree  = ~(st.sync[1] ^ st.sync[2]);
    assign newLvl = (agree & st.sync[2]) | (~agree & st.lvl);
    assign aCh    = newLvl[PIN_AP] ^ st.lvl[PIN_AP];
    assign bCh    = newLvl[PIN_BP] ^ st.lvl[PIN_BP];
    assign fwd    = (aCh & (newLvl[PIN_AP] ^ newLvl[PIN_BP]))
                  | (bCh & ~(newLvl[PIN_AP] ^ newLvl[PIN_BP]));
    assign bad    = (newLvl[PIN_AP] == newLvl[PIN_AN])
                  | (newLvl[PIN_BP] == newLvl[PIN_BN])
                  | (newLvl[PIN_RP] == newLvl[PIN_RN]);
    assign step   = (aCh ^ bCh) & ~bad;
    assign lvlEqA = st.lvl[PIN_AP] == st.lvl[PIN_AN];
    assign lvlBad = lvlEqA | (st.lvl[PIN_BP] == st.lvl[PIN_BN])
                  | (st.lvl[PIN_RP] == st.lvl[PIN_RN]);

    always_comb begin
        next_st         = st;
        next_st.sync[0] = pins;
        next_st.sync[1] = st.sync[0];
        next_st.sync[2] = st.sync[1];
        next_st.lvl     = newLvl;
        next_st.badPrev = bad;
        // An edge of one track alone, with no pair fault, moves the count by one.
        if (step) begin
            if (fwd ^ invert) begin
                next_st.pos = st.pos + POS_W'(1);
            end else begin
                next_st.pos = st.pos - POS_W'(1);
            end
        end
        // A single glitch while both wires of a pair cross is not a fault.
        next_st.errPulse = ~newLvl[PIN_FN]
                         | (bad & st.badPrev)
                         | (aCh & bCh);
        next_st.refPulse = newLvl[PIN_RP] & ~st.lvl[PIN_RP] & ~bad;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st <= RST;
        end else begin
            st <= next_st;
        end
    end

    assign position = st.pos;
    assign errPulse = st.errPulse;
    assign refPulse = st.refPulse;

    ////////////////////////////////////////////////////////////////////////////
    sync_accept_a: assert property ((pins == $past(pins)) [*4] |-> st.lvl == pins)
        else $error("stable pins not accepted after synchroniser");
    count_step_a: assert property (step |=> (st.pos - $past(st.pos) == POS_W'(1))
        || ($past(st.pos) - st.pos == POS_W'(1)))
        else $error("legal edge did not move count by one");
    dir_invert_a: assert property (step && fwd && invert |=>
        st.pos == $past(st.pos) - POS_W'(1))
        else $error("inverted axis counted the wrong way");
    double_edge_a: assert property (aCh && bCh |=>
        st.errPulse && st.pos == $past(st.pos))
        else $error("double track change not flagged or counted");
    fault_line_a: assert property (!st.lvl[PIN_FN] |-> st.errPulse)
        else $error("fault line active without error pulse");
    tristate_a: assert property (lvlEqA [*2] |-> st.errPulse)
        else $error("undriven pair not flagged");
    ref_event_a: assert property ($rose(st.lvl[PIN_RP]) && !lvlBad |-> st.refPulse)
        else $error("reference edge not reported");

endmodule : seu_axis

// ===== verilog/seu_top.sv
// Servo encoder and setpoint unit: axis decoders, setpoint codes, registers.
// Assumes a plain register port on ref_clk and an asynchronous ready pin.
//
// Function
// - Count every edge of both tracks, four counts per signal period.
// - Decode correctly with track frequencies up to 500 kHz.
// - Edges may come 250 ns apart and the decoder must resolve them.
// - Each input takes two tracks, reference, their complements and a fault line.
// - An active encoder fault line flags a measuring error on that axis.
// - Undriven encoder outputs also flag a measuring error.
// - An undriven fault line reads inactive and never flags an error.
// - Counting direction is inverted by a setting, not by rewiring tracks.
// - Six inputs and seven outputs in full form, fewer in reduced forms.
// - Each setpoint output carries its axis's commanded speed code.
// - One setpoint step is nominally 406 microvolts.
// - Rapid traverse speed maps to 10 volts, sign gives direction.
// - Ready low forces every setpoint to the zero code at once.
// - Zero is held up to 1 s; drives must be off within it.
module seu_top
    import seu_pkg::*;
#(
    parameter int NUM_IN   = NUM_IN_DEF,
    parameter int NUM_OUT  = NUM_OUT_DEF,
    parameter int HOLD_CYC = HOLD_CYC_DEF
) (
    // Clock and reset.
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    // Register port.
    input  wire logic [AW-1:0]                 regAddr,
    input  wire logic [DW-1:0]                 regWrData,
    input  wire logic                          regWrStb,
    input  wire logic                          regRdStb,
    output logic      [DW-1:0]                 regRdData,
    // Measuring inputs.
    input  wire logic [NUM_IN-1:0]             encAP,
    input  wire logic [NUM_IN-1:0]             encAN,
    input  wire logic [NUM_IN-1:0]             encBP,
    input  wire logic [NUM_IN-1:0]             encBN,
    input  wire logic [NUM_IN-1:0]             encRP,
    input  wire logic [NUM_IN-1:0]             encRN,
    input  wire logic [NUM_IN-1:0]             encFaultN,
    // Drive side.
    input  wire logic                          readyIn,
    output logic      [NUM_OUT-1:0][SP_W-1:0]  spCode,
    // Interrupt.
    output logic                               irq
);

    localparam int HOLD_W = $clog2(HOLD_CYC + 1);

    typedef struct packed {
        logic [NUM_IN-1:0]             invert;
        logic [DW-1:0]                 status;
        logic [DW-1:0]                 mask;
        logic [NUM_OUT-1:0][SP_W-1:0]  spReq;
        logic [NUM_OUT-1:0][SP_W-1:0]  spOut;
        logic [DW-1:0]                 rdData;
        logic [2:0]                    rdySync;
        logic                          readyLvl;
        logic [HOLD_W-1:0]             holdCnt;
        logic                          holdDone;
    } seu_state_type;

    // Hold starts expired so power-up with ready low raises no late event.
    localparam seu_state_type RST = '{holdDone: 1'b1, default: '0};

    seu_state_type st;
    seu_state_type next_st;

    logic [NUM_IN-1:0][POS_W-1:0] posBus;
    logic [NUM_IN-1:0]            errEvt;
    logic [NUM_IN-1:0]            refEvt;
    logic [2:0]                   page;
    logic [2:0]                   idx;
    logic                         wrSp;
    logic [DW-1:0]                clrMask;
    logic [DW-1:0]                setMask;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////
    // Axis decoders, one per measuring input.
    generate
        for (genvar g = 0; g < NUM_IN; g++) begin : gAxis
            seu_axis uAxis (
                .ref_clk  (ref_clk),
                .resetn   (resetn),
                .pins     ({encFaultN[g], encRN[g], encRP[g], encBN[g],
                            encBP[g], encAN[g], encAP[g]}),
                .invert   (st.invert[g]),
                .position (posBus[g]),
                .errPulse (errEvt[g]),
                .refPulse (refEvt[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Saturate a signed write to the setpoint code range.
    function automatic logic [SP_W-1:0] sat_code(input logic [DW-1:0] d);
        logic signed [DW-1:0] s;
        s = $signed(d);
        if (s > SP_MAX) begin
            return SP_W'(SP_MAX);
        end else if (s < SP_MIN) begin
            return SP_W'(SP_MIN);
        end
        return d[SP_W-1:0];
    endfunction : sat_code

    assign page    = regAddr[AW-1:PAGE_LSB];
    assign idx     = regAddr[PAGE_LSB-1:REG_LSB];
    assign wrSp    = regWrStb && page == SP_PAGE && int'(idx) < NUM_OUT;
    assign clrMask = (regWrStb && regAddr == REG_STATUS) ? regWrData : '0;

    always_comb begin
        setMask                           = '0;
        setMask[ST_ERR_LSB +: NUM_IN]     = errEvt;
        setMask[ST_REF_LSB +: NUM_IN]     = refEvt;
        // Both events come from the current state so this never loops through next_st.
        setMask[ST_DROP_BIT]              = st.readyLvl & ~st.rdySync[2]
                                          & (st.rdySync[1] == st.rdySync[2]);
        setMask[ST_HOLD_BIT]              = ~st.readyLvl & ~st.holdDone
                                          & (st.holdCnt == HOLD_W'(HOLD_CYC - 1));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready pin, forced zero and hold window.
    always_comb begin
        next_st            = st;
        next_st.rdySync[0] = readyIn;
        next_st.rdySync[1] = st.rdySync[0];
        next_st.rdySync[2] = st.rdySync[1];
        if (st.rdySync[1] == st.rdySync[2]) begin
            next_st.readyLvl = st.rdySync[2];
        end
        if (st.readyLvl) begin
            next_st.holdCnt  = '0;
            next_st.holdDone = 1'b0;
        end else if (!st.holdDone) begin
            if (st.holdCnt == HOLD_W'(HOLD_CYC - 1)) begin
                next_st.holdDone = 1'b1;
            end else begin
                next_st.holdCnt = st.holdCnt + HOLD_W'(1);
            end
        end
        // The zero code stays after the window; drives are expected off by then.
        for (int i = 0; i < NUM_OUT; i++) begin
            next_st.spOut[i] = st.readyLvl ? st.spReq[i] : '0;
        end

        // Register writes; hardware sets win over a clear in the same cycle.
        if (regWrStb && regAddr == REG_CTRL) begin
            next_st.invert = regWrData[NUM_IN-1:0];
        end
        if (regWrStb && regAddr == REG_MASK) begin
            next_st.mask = regWrData;
        end
        if (wrSp) begin
            next_st.spReq[idx] = sat_code(regWrData);
        end
        next_st.status = (st.status & ~clrMask) | setMask;

        // Read data stands for exactly one cycle after the strobe.
        next_st.rdData = '0;
        if (regRdStb) begin
            if (regAddr == REG_CTRL) begin
                next_st.rdData = DW'(st.invert);
            end else if (regAddr == REG_STATUS) begin
                next_st.rdData = st.status;
            end else if (regAddr == REG_MASK) begin
                next_st.rdData = st.mask;
            end else if (regAddr == REG_LEVEL) begin
                next_st.rdData[LV_READY] = st.readyLvl;
                next_st.rdData[LV_HOLD]  = st.holdDone;
            end else if (regAddr == REG_RAPID) begin
                next_st.rdData = DW'(SP_RAPID);
            end else if (page == POS_PAGE && int'(idx) < NUM_IN) begin
                next_st.rdData = posBus[idx];
            end else if (page == SP_PAGE && int'(idx) < NUM_OUT) begin
                next_st.rdData = DW'($signed(st.spReq[idx]));
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st <= RST;
        end else begin
            st <= next_st;
        end
    end

    assign regRdData = st.rdData;
    assign spCode    = st.spOut;
    assign irq       = |(st.status & st.mask);

    ////////////////////////////////////////////////////////////////////////////
    zero_force_a: assert property (!st.readyLvl |=> st.spOut == '0)
        else $error("setpoints not zero while ready is low");
    follow_cmd_a: assert property (st.readyLvl |=> st.spOut == $past(st.spReq))
        else $error("setpoint output does not follow command");
    hold_window_a: assert property ($rose(st.holdDone) |->
        $past(st.holdCnt) == HOLD_W'(HOLD_CYC - 1) && !st.readyLvl)
        else $error("hold window ended at wrong count");
    sticky_stat_a: assert property (1'b1 |=>
        (($past(st.status) & ~$past(clrMask)) & ~st.status) == '0)
        else $error("status bit lost without a clear");
    err_latch_a: assert property (|errEvt |=>
        (st.status[ST_ERR_LSB +: NUM_IN] & $past(errEvt)) == $past(errEvt))
        else $error("axis error not latched");
    sat_high_a: assert property (wrSp && $signed(regWrData) > SP_MAX |=>
        st.spReq[$past(idx)] == SP_W'(SP_MAX))
        else $error("large setpoint did not saturate");
    read_once_a: assert property (!regRdStb |=> st.rdData == '0)
        else $error("read data held past its cycle");
    stat_clear_a: assert property (regWrStb && regAddr == REG_STATUS |=>
        (st.status & $past(regWrData) & ~$past(setMask)) == '0)
        else $error("written one did not clear status bit");
    ref_latch_a: assert property (|refEvt |=>
        (st.status[ST_REF_LSB +: NUM_IN] & $past(refEvt)) == $past(refEvt))
        else $error("reference event not latched");
    drop_event_a: assert property ($fell(st.readyLvl) |-> st.status[ST_DROP_BIT])
        else $error("ready drop not reported");
    hold_restart_a: assert property (st.readyLvl |=>
        !st.holdDone && st.holdCnt == '0)
        else $error("hold window did not restart with ready");
    zero_after_a: assert property (st.holdDone && !st.readyLvl |-> st.spOut == '0)
        else $error("setpoint left zero after hold window");
    sat_low_a: assert property (wrSp && $signed(regWrData) < SP_MIN |=>
        st.spReq[$past(idx)] == SP_W'(SP_MIN))
        else $error("small setpoint did not saturate");
    mask_write_a: assert property (regWrStb && regAddr == REG_MASK |=>
        st.mask == $past(regWrData))
        else $error("mask write not taken");
    invert_write_a: assert property (regWrStb && regAddr == REG_CTRL |=>
        st.invert == NUM_IN'($past(regWrData)))
        else $error("direction setting not taken");
    stat_read_a: assert property (regRdStb && regAddr == REG_STATUS |=>
        st.rdData == $past(st.status))
        else $error("status read returned wrong word");
    rapid_read_a: assert property (regRdStb && regAddr == REG_RAPID |=>
        st.rdData == DW'(SP_RAPID))
        else $error("rapid traverse code read wrong");
    ready_sync_a: assert property (st.rdySync[1] == st.rdySync[2] |=>
        st.readyLvl == $past(st.rdySync[2]))
        else $error("agreed ready level not taken");

endmodule : seu_top

// ===== tb/seu_enc_model.sv
// Encoder model: quadrature tracks, reference and fault line for every axis.
// Assumes the bench calls step and sets faultOn, refOn and hiZ after an edge.
module seu_enc_model
    import seu_pkg::*;
#(
    parameter int N = NUM_IN_DEF
) (
    // Clock.
    input  wire logic        ref_clk,
    // Encoder pins.
    output logic     [N-1:0] encAP,
    output logic     [N-1:0] encAN,
    output logic     [N-1:0] encBP,
    output logic     [N-1:0] encBN,
    output logic     [N-1:0] encRP,
    output logic     [N-1:0] encRN,
    output logic     [N-1:0] encFaultN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]   phase [N] = '{default: 2'h0};
    logic [N-1:0] faultOn   = '0;
    logic [N-1:0] refOn     = '0;
    logic [N-1:0] hiZ       = '0;

    // Released drivers leave both wires of a pair at one bias level, so the
    // receiver sees no difference instead of a valid level.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            encAP[i] = hiZ[i] ? 1'b0 : (phase[i] == 2'h1 || phase[i] == 2'h2);
            encAN[i] = hiZ[i] ? 1'b0 : !(phase[i] == 2'h1 || phase[i] == 2'h2);
            encBP[i] = hiZ[i] ? 1'b0 : phase[i][1];
            encBN[i] = hiZ[i] ? 1'b0 : ~phase[i][1];
            encRP[i] = hiZ[i] ? 1'b0 : refOn[i];
            encRN[i] = hiZ[i] ? 1'b0 : ~refOn[i];
            encFaultN[i] = ~faultOn[i];
        end
    end

    ////////////////////////////////////////////////////////////
    // Phase step of d (one track edge for d of 1 or -1), then the minimum edge spacing of 5 cycles.
    task automatic step(input int i, input int d);
        phase[i] <= phase[i] + 2'(d);
        repeat (5) @(posedge ref_clk);
    endtask : step
endmodule : seu_enc_model

// ===== tb/seu_top_bench.sv
// Bench for the servo encoder and setpoint unit, with queued read checks.
// Assumes a 20 MHz clock and the encoder model of seu_enc_model.
module seu_top_bench
    import seu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD_T = 20;
    logic                       ref_clk   = 1'b0;
    logic                       resetn    = 1'b0;
    logic [AW-1:0]              regAddr   = '0;
    logic [DW-1:0]              regWrData = '0;
    logic                       regWrStb  = 1'b0;
    logic                       regRdStb  = 1'b0;
    logic                       readyIn   = 1'b1;
    logic [DW-1:0]              regRdData;
    logic [NUM_OUT_DEF-1:0][15:0] spCode;
    logic                       irq;
    logic [NUM_IN_DEF-1:0]      encAP, encAN, encBP, encBN, encRP, encRN, encFaultN;
    logic [31:0]                expQ [$];
    string                      nameQ [$];
    logic                       rdSeen    = 1'b0;
    logic [15:0]                spExp [NUM_OUT_DEF];
    logic [31:0]                seed, v;
    int                         failCount = 0;
    int                         checked   = 0;

    always #25 ref_clk = ~ref_clk;

    seu_top #(.HOLD_CYC(HOLD_T)) u_seu_top (.ref_clk(ref_clk), .resetn(resetn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .encAP(encAP), .encAN(encAN), .encBP(encBP), .encBN(encBN),
        .encRP(encRP), .encRN(encRN), .encFaultN(encFaultN), .readyIn(readyIn),
        .spCode(spCode), .irq(irq));
    seu_enc_model u_seu_enc_model (.ref_clk(ref_clk), .encAP(encAP), .encAN(encAN),
        .encBP(encBP), .encBN(encBN), .encRP(encRP), .encRN(encRN), .encFaultN(encFaultN));

    ////////////////////////////////////////////////////////////
    // Helpers.
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [15:0] sat(input logic [31:0] x);
        if ($signed(x) > 32767) return 16'h7FFF;
        if ($signed(x) < -32768) return 16'h8000;
        return x[15:0];
    endfunction : sat
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : waitc
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, input logic [31:0] e, input string nm);
        expQ.push_back(e);
        nameQ.push_back(nm);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task automatic testDone;
        $display("checks %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : testDone

    // Read data stand only in the cycle after the strobe.
    always @(posedge ref_clk) begin
        if (rdSeen) check(nameQ.pop_front(), expQ.pop_front(), regRdData);
        rdSeen <= regRdStb;
    end

    initial begin
        waitc(3000);
        failCount++;
        testDone;
    end

    ////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        waitc(4);
        resetn <= 1'b1;
        waitc(6);
        rd(REG_CTRL, 0, "ctrl");
        rd(REG_STATUS, 0, "status");
        rd(REG_MASK, 0, "mask");
        rd(REG_LEVEL, 1, "level");
        rd(REG_RAPID, 32'(SP_RAPID_MV * 1000 / SP_LSB_UV), "rapid");
        rd(8'hFC, 0, "unmapped");
        for (int k = 0; k < 8; k++) u_seu_enc_model.step(0, 1);
        for (int k = 0; k < 3; k++) u_seu_enc_model.step(3, -1);
        rd(8'h20, 8, "pos0");
        rd(8'h2C, 32'hFFFFFFFD, "pos3");
        rd(8'h34, 0, "pos5");
        wr(REG_CTRL, 1);
        for (int k = 0; k < 4; k++) u_seu_enc_model.step(0, 1);
        rd(8'h20, 4, "posInv");
        rd(REG_STATUS, 0, "status");
        wr(REG_MASK, 1);
        u_seu_enc_model.faultOn[0] <= 1'b1;
        waitc(8);
        check("irq", 1, {31'h0, irq});
        u_seu_enc_model.faultOn[0] <= 1'b0;
        waitc(8);
        rd(REG_STATUS, 1, "status");
        wr(REG_STATUS, 1);
        check("irq", 0, {31'h0, irq});
        rd(REG_STATUS, 0, "status");
        u_seu_enc_model.hiZ[1] <= 1'b1;
        waitc(6);
        u_seu_enc_model.hiZ[1] <= 1'b0;
        waitc(10);
        rd(REG_STATUS, 2, "status");
        wr(REG_STATUS, '1);
        u_seu_enc_model.step(2, 2);
        rd(REG_STATUS, 4, "status");
        wr(REG_STATUS, '1);
        u_seu_enc_model.refOn[4] <= 1'b1;
        waitc(6);
        u_seu_enc_model.refOn[4] <= 1'b0;
        waitc(6);
        rd(REG_STATUS, 32'h1000, "status");
        wr(REG_STATUS, '1);
        seed = 32'hE26F;
        for (int i = 0; i < NUM_OUT_DEF; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 32'h7FFF0000 : (i == 1) ? 32'h80000000 : seed;
            spExp[i] = sat(v);
            wr(8'(8'h40 + 4 * i), v);
        end
        waitc(2);
        for (int i = 0; i < NUM_OUT_DEF; i++) begin
            check("spCode", {16'h0, spExp[i]}, {16'h0, spCode[i]});
            rd(8'(8'h40 + 4 * i), {{16{spExp[i][15]}}, spExp[i]}, "setpoint");
        end
        readyIn <= 1'b0;
        waitc(6);
        for (int i = 0; i < NUM_OUT_DEF; i++) check("spZero", 0, {16'h0, spCode[i]});
        rd(REG_STATUS, 32'h10000, "status");
        waitc(30);
        rd(REG_STATUS, 32'h30000, "status");
        rd(REG_LEVEL, 2, "level");
        check("spHeld", 0, {16'h0, spCode[0]});
        waitc(3);
        testDone;
    end
endmodule : seu_top_bench
